// ---- logic/pulse_trigger_params.svh ----
`ifndef PULSE_TRIGGER_PARAMS_SVH
`define PULSE_TRIGGER_PARAMS_SVH

// ==========================================================================
// Register offsets
`define PT_ADDR_CMD 8'h00
`define PT_ADDR_WIDTH 8'h04
`define PT_ADDR_DUTY 8'h08
`define PT_ADDR_DELAY 8'h0c
`define PT_ADDR_STATUS 8'h10
`define PT_ADDR_MIN_SPAN 8'h14
`define PT_ADDR_MIN_START 8'h18

// ==========================================================================
// Timing
`define PT_CLK_NS 25
`define PT_TICK_NS 100
`define PT_TICK_CYCLES (`PT_TICK_NS / `PT_CLK_NS)
`define PT_MAX_TIME_NS 40880000
`define PT_MAX_TICKS (`PT_MAX_TIME_NS / `PT_TICK_NS)
`define PT_WIDTH_RESET_NS 10000
`define PT_DELAY_RESET_NS 5000
`define PT_WIDTH_RESET_TICKS (`PT_WIDTH_RESET_NS / `PT_TICK_NS)
`define PT_DELAY_RESET_TICKS (`PT_DELAY_RESET_NS / `PT_TICK_NS)
`define PT_DUTY_RESET 10
`define PT_DUTY_MAX 100
`define PT_MIN_PERIOD_TICKS 2

// ==========================================================================
// Profile resolution
`define PT_RES_THR_0 100
`define PT_RES_THR_1 1000
`define PT_RES_THR_2 10000
`define PT_RES_TICKS_0 1
`define PT_RES_TICKS_1 2
`define PT_RES_TICKS_2 10
`define PT_RES_TICKS_3 100
`define PT_SPAN_SAMPLES 100
`define PT_START_PERIODS 6

// ==========================================================================
// Status bit positions
`define PT_ST_WIDE 0
`define PT_ST_LOW_POL 1
`define PT_ST_EXT 2
`define PT_ST_PROFILE 3
`define PT_ST_RES_LSB 4

`endif

// ---- logic/pulse_trigger_pkg.sv ----
package pulse_trigger_pkg;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_SELECT_PRECISION_DETECTOR = 4'h1,
        CMD_SELECT_WIDE_DETECTOR = 4'h2,
        CMD_INTERNAL_TRIGGER = 4'h3,
        CMD_EXTERNAL_TRIGGER = 4'h4,
        CMD_POLARITY_HIGH = 4'h5,
        CMD_POLARITY_LOW = 4'h6,
        CMD_PROFILE_DOMAIN = 4'h7,
        CMD_FREQUENCY_DOMAIN = 4'h8
    } cmd_t;

    typedef enum logic [1:0] {
        RES_100NS,
        RES_200NS,
        RES_1US,
        RES_10US
    } res_t;

    typedef struct packed {
        res_t res;
        logic profile;
        logic ext;
        logic low_pol;
        logic wide;
    } status_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage

// ---- logic/pulse_trigger_timing_control.sv ----
`timescale 1ns/10ps
`include "pulse_trigger_params.svh"

// Function
// - Pulse width programmable up to 40.88 ms; reset value ten microseconds.
// - Internal trigger keeps duty cycle at or below limit, reset ten percent.
// - High polarity: output high during pulse on time, low otherwise.
// - Low polarity: output low during pulse on time, high otherwise.
// - Frequency domain waits programmable delay, reset 5 us, before measuring.
// - Internal measurement trigger after reset until external is selected.
// - External mode: a falling trigger input edge starts a measurement when no pulse or delay is running.
// - Two detector paths by command: precision 10 kHz, wide 1.5 MHz.
// - Profile domain forces wide path; reset leaves precision path.
// - Width write sets profile resolution, minimum span and start time.
// - Status read reports detector, polarity, trigger mode and domain.
module pulse_trigger_timing_control #(
    parameter int unsigned MAX_TICKS = `PT_MAX_TICKS,
    parameter int unsigned WIDTH_RESET_TICKS = `PT_WIDTH_RESET_TICKS,
    parameter int unsigned DELAY_RESET_TICKS = `PT_DELAY_RESET_TICKS
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_trig_in,
    output logic o_pulse,
    output logic o_meas_start,
    output logic o_wide_path,
    output logic o_profile_domain
);
    import pulse_trigger_pkg::*;

    // ======================================================================
    // Timebase
    // Widths, delays and periods all count this tick, never raw clocks
    localparam logic [1:0] TICK_LAST = 2'(`PT_TICK_CYCLES - 1);
    logic [1:0] tb_reg;
    logic tick;

    assign tick = (tb_reg == TICK_LAST);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || tick) begin
            tb_reg <= 2'h0;
        end else begin
            tb_reg <= tb_reg + 2'h1;
        end
    end

    // ======================================================================
    // Register bus
    bus_req_t req;
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    logic wr_cmd;
    logic wr_width;
    logic wr_duty;
    logic wr_delay;
    cmd_t cmd;
    assign wr_cmd = req.wr && (req.addr == `PT_ADDR_CMD);
    assign wr_width = req.wr && (req.addr == `PT_ADDR_WIDTH);
    assign wr_duty = req.wr && (req.addr == `PT_ADDR_DUTY);
    assign wr_delay = req.wr && (req.addr == `PT_ADDR_DELAY);
    assign cmd = cmd_t'(req.wdata[3:0]);

    // Values arrive in ns; the clamp first keeps the rounding sum in range
    localparam logic [31:0] MAX_NS = 32'(`PT_MAX_TIME_NS);
    localparam logic [31:0] HALF_TICK = 32'(`PT_TICK_NS / 2);
    localparam logic [31:0] TICK_NS = 32'(`PT_TICK_NS);
    logic [31:0] ns_clamped;
    logic [31:0] ticks_rounded;
    logic [18:0] ticks_in;
    assign ns_clamped = (req.wdata > MAX_NS) ? MAX_NS : req.wdata;
    assign ticks_rounded = (ns_clamped + HALF_TICK) / TICK_NS;
    // MAX_TICKS trims the range for a build with shorter counters
    assign ticks_in = (ticks_rounded > 32'(MAX_TICKS))
                      ? 19'(MAX_TICKS) : 19'(ticks_rounded);

    logic [18:0] width_reg;
    logic [18:0] delay_reg;
    logic [6:0] duty_reg;
    logic [6:0] duty_in;
    localparam logic [31:0] DUTY_MAX = 32'(`PT_DUTY_MAX);
    assign duty_in = (req.wdata > DUTY_MAX) ? 7'(`PT_DUTY_MAX)
                                            : req.wdata[6:0];

    logic wide_reg;
    logic low_pol_reg;
    logic ext_reg;
    logic profile_reg;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            width_reg <= 19'(WIDTH_RESET_TICKS);
            delay_reg <= 19'(DELAY_RESET_TICKS);
            duty_reg <= 7'(`PT_DUTY_RESET);
        end else begin
            if (wr_width) begin
                width_reg <= ticks_in;
            end
            if (wr_delay) begin
                delay_reg <= ticks_in;
            end
            if (wr_duty) begin
                duty_reg <= duty_in;
            end
        end
    end

    // Entering profile domain drags the detector to wide; leaving it
    // keeps wide so the frequency domain only changes on an explicit command
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wide_reg <= 1'b0;
            low_pol_reg <= 1'b0;
            ext_reg <= 1'b0;
            profile_reg <= 1'b0;
        end else if (wr_cmd) begin
            // Codes outside the table fall to default and change nothing
            case (cmd)
                CMD_SELECT_PRECISION_DETECTOR: begin
                    wide_reg <= profile_reg;
                end
                CMD_SELECT_WIDE_DETECTOR: wide_reg <= 1'b1;
                CMD_INTERNAL_TRIGGER: ext_reg <= 1'b0;
                CMD_EXTERNAL_TRIGGER: ext_reg <= 1'b1;
                CMD_POLARITY_HIGH: low_pol_reg <= 1'b0;
                CMD_POLARITY_LOW: low_pol_reg <= 1'b1;
                CMD_PROFILE_DOMAIN: begin
                    profile_reg <= 1'b1;
                    wide_reg <= 1'b1;
                end
                CMD_FREQUENCY_DOMAIN: profile_reg <= 1'b0;
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // Profile resolution, span and start limits
    // Longer pulses get coarser samples so a profile keeps its point count
    res_t res;
    logic [6:0] res_ticks;
    assign res = (width_reg <= 19'(`PT_RES_THR_0)) ? RES_100NS :
                 (width_reg <= 19'(`PT_RES_THR_1)) ? RES_200NS :
                 (width_reg <= 19'(`PT_RES_THR_2)) ? RES_1US : RES_10US;
    assign res_ticks = (res == RES_100NS) ? 7'(`PT_RES_TICKS_0) :
                       (res == RES_200NS) ? 7'(`PT_RES_TICKS_1) :
                       (res == RES_1US) ? 7'(`PT_RES_TICKS_2)
                                        : 7'(`PT_RES_TICKS_3);

    logic [31:0] min_span;
    logic [31:0] min_start;
    assign min_span = 32'(res_ticks) * 32'(`PT_SPAN_SAMPLES);
    // Negative: a profile may open this far ahead of the pulse edge
    assign min_start = 32'h0 - 32'(res_ticks) * 32'(`PT_START_PERIODS);

    // ======================================================================
    // Trigger input synchroniser and falling edge
    // Both stages reset to the idle high level: no false edge on release
    logic trig_s1_reg;
    logic trig_s2_reg;
    logic trig_prev_reg;
    logic trig_fall;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            trig_s1_reg <= 1'b1;
            trig_s2_reg <= 1'b1;
            trig_prev_reg <= 1'b1;
        end else begin
            trig_s1_reg <= i_trig_in;
            trig_s2_reg <= trig_s1_reg;
            trig_prev_reg <= trig_s2_reg;
        end
    end

    assign trig_fall = trig_prev_reg && !trig_s2_reg;

    // ======================================================================
    // Pulse sequencer
    typedef enum logic [1:0] {
        PS_IDLE,
        PS_ON,
        PS_OFF
    } pulse_state_t;

    pulse_state_t ps_reg;
    pulse_state_t ps_next;
    logic [26:0] per_reg;
    logic [26:0] per_next;
    logic int_ok;
    logic width_done;
    logic duty_met;
    logic start_pulse;
    logic mode_reg;

    // Period is stretched until width*100 <= period*duty; compare, no divide
    assign duty_met = (34'(per_reg) * 34'(duty_reg))
                      >= (34'(width_reg) * 34'(`PT_DUTY_MAX));
    assign int_ok = (duty_reg != 7'h0) && (width_reg != 19'h0);
    assign width_done = tick && (per_reg + 27'h1 >= 27'(width_reg));

    always_comb begin
        ps_next = ps_reg;
        per_next = per_reg;
        start_pulse = 1'b0;
        // Saturate so a very long off time never wraps to a short period
        if (tick && per_reg != {27{1'b1}}) begin
            per_next = per_reg + 27'h1;
        end
        case (ps_reg)
            PS_IDLE: begin
                if (ext_reg ? (trig_fall && width_reg != 19'h0)
                            : int_ok) begin
                    start_pulse = 1'b1;
                end
            end
            PS_ON: begin
                if (width_done) begin
                    ps_next = ext_reg ? PS_IDLE : PS_OFF;
                end
            end
            PS_OFF: begin
                if (tick && duty_met
                    && per_reg >= 27'(`PT_MIN_PERIOD_TICKS)) begin
                    start_pulse = int_ok;
                    ps_next = int_ok ? PS_ON : PS_IDLE;
                end
            end
            default: ps_next = PS_IDLE;
        endcase
        if (start_pulse) begin
            ps_next = PS_ON;
            per_next = 27'h0;
        end
        // A trigger mode change aborts the pulse in flight; restart is clean
        if (mode_reg != ext_reg) begin
            ps_next = PS_IDLE;
            per_next = 27'h0;
            start_pulse = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ps_reg <= PS_IDLE;
            per_reg <= 27'h0;
            mode_reg <= 1'b0;
        end else begin
            ps_reg <= ps_next;
            per_reg <= per_next;
            mode_reg <= ext_reg;
        end
    end

    // Output flop; the polarity bit only inverts the sense of the on time
    logic pulse_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= (ps_next == PS_ON) ^ low_pol_reg;
        end
    end

    // ======================================================================
    // Measurement trigger delay
    logic dly_busy_reg;
    logic [18:0] dly_cnt_reg;
    logic meas_reg;
    logic no_delay;
    logic dly_done;

    // Triggers landing while a delay runs are dropped, not queued
    assign no_delay = profile_reg || (delay_reg == 19'h0);
    // Entering the profile domain ends a running delay at once
    assign dly_done = dly_busy_reg
                      && (profile_reg || (tick
                      && (dly_cnt_reg + 19'h1 >= delay_reg)));

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            dly_busy_reg <= 1'b0;
            dly_cnt_reg <= 19'h0;
            meas_reg <= 1'b0;
        end else begin
            meas_reg <= 1'b0;
            if (dly_busy_reg) begin
                if (dly_done) begin
                    dly_busy_reg <= 1'b0;
                    meas_reg <= 1'b1;
                end else if (tick) begin
                    dly_cnt_reg <= dly_cnt_reg + 19'h1;
                end
            end else if (start_pulse) begin
                if (no_delay) begin
                    meas_reg <= 1'b1;
                end else begin
                    dly_busy_reg <= 1'b1;
                    dly_cnt_reg <= 19'h0;
                end
            end
        end
    end

    // ======================================================================
    // Read path
    status_t status;
    assign status = '{res: res, profile: profile_reg, ext: ext_reg,
                      low_pol: low_pol_reg, wide: wide_reg};

    logic [31:0] rd_mux;
    assign rd_mux =
        (req.addr == `PT_ADDR_WIDTH) ? 32'(width_reg) :
        (req.addr == `PT_ADDR_DUTY) ? 32'(duty_reg) :
        (req.addr == `PT_ADDR_DELAY) ? 32'(delay_reg) :
        (req.addr == `PT_ADDR_STATUS) ? 32'(status) :
        (req.addr == `PT_ADDR_MIN_SPAN) ? min_span :
        (req.addr == `PT_ADDR_MIN_START) ? min_start : 32'h0;

    // Data stand one cycle then fall back to zero, so stale data never reads
    logic [31:0] rdata_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= req.rd ? rd_mux : 32'h0;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_pulse = pulse_reg;
    assign o_meas_start = meas_reg;
    assign o_wide_path = wide_reg;
    assign o_profile_domain = profile_reg;

endmodule // pulse_trigger_timing_control

// ---- verif/pulse_trigger_timing_control_checker.sv ----
`timescale 1ns/10ps
`include "pulse_trigger_params.svh"
// ==========================================
// Port checks
module pulse_trigger_timing_control_checker (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_trig_in,
    input wire logic o_pulse,
    input wire logic o_meas_start,
    input wire logic o_wide_path,
    input wire logic o_profile_domain
);
    import pulse_trigger_pkg::*;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);
    wire cmd_wr = i_wr && i_addr == `PT_ADDR_CMD;
    wire st_rd = i_rd && i_addr == `PT_ADDR_STATUS;
    wire [3:0] code = i_wdata[3:0];
    AST_RDATA_IDLE: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata not idle");
    AST_RESET_STATE: assert property (
        $past(i_srst) |-> !o_wide_path && !o_profile_domain)
        else $error("reset state wrong");
    AST_PROFILE_WIDE: assert property (
        o_profile_domain |-> o_wide_path) else $error("profile not wide");
    AST_WIDE_CMD: assert property (
        cmd_wr && code == CMD_SELECT_WIDE_DETECTOR |=> o_wide_path)
        else $error("wide command lost");
    AST_PREC_CMD: assert property (
        cmd_wr && code == CMD_SELECT_PRECISION_DETECTOR && !o_profile_domain
        |=> !o_wide_path) else $error("precision command lost");
    AST_PROFILE_CMD: assert property (
        cmd_wr && code == CMD_PROFILE_DOMAIN |=> o_profile_domain)
        else $error("profile command lost");
    AST_MODE_HOLD: assert property (
        !cmd_wr |=> $stable({o_wide_path, o_profile_domain}))
        else $error("mode changed without command");
    AST_MEAS_PULSE: assert property (
        o_meas_start |=> !o_meas_start) else $error("start not one cycle");
    AST_STATUS_BITS: assert property (
        st_rd |=> o_rdata[`PT_ST_WIDE] == $past(o_wide_path) &&
        o_rdata[`PT_ST_PROFILE] == $past(o_profile_domain))
        else $error("status disagrees with outputs");
    cover property (o_meas_start);
    cover property (cmd_wr && code == CMD_PROFILE_DOMAIN);
    cover property (st_rd);
endmodule // pulse_trigger_timing_control_checker

bind pulse_trigger_timing_control
    pulse_trigger_timing_control_checker chk_u (
    .i_sys_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_trig_in, .o_pulse, .o_meas_start, .o_wide_path, .o_profile_domain);

// ---- verif/pulse_partner_model.sv ----
`timescale 1ns/10ps
// ==========================================
// Trigger source and pulse modulator
module pulse_partner_model (
    input wire logic i_sys_clk,
    input wire logic i_pulse,
    input wire logic i_low_pol,
    output logic o_trig_n,
    output int o_on_cnt,
    output int o_on_len,
    output int o_on_cyc
);
    logic on_d = 1'b0;
    int run = 0;
    // Modulator sees the on period through the selected polarity
    wire on_now = i_pulse ^ i_low_pol;
    initial begin
        o_trig_n = 1'b1;
        o_on_cnt = 0;
        o_on_len = 0;
        o_on_cyc = 0;
    end
    always @(posedge i_sys_clk) begin
        on_d <= on_now;
        run <= on_now ? run + 1 : 0;
        if (on_now)
            o_on_cyc <= o_on_cyc + 1;
        if (on_now && !on_d)
            o_on_cnt <= o_on_cnt + 1;
        if (!on_now && on_d)
            o_on_len <= run;
    end
    // TTL line idles high; one falling edge per wanted measurement
    task automatic fire(input int hold);
        @(posedge i_sys_clk);
        o_trig_n <= 1'b0;
        repeat (hold) @(posedge i_sys_clk);
        o_trig_n <= 1'b1;
    endtask
endmodule // pulse_partner_model

// ---- verif/pulse_trigger_timing_control_tb_top.sv ----
`timescale 1ns/10ps
`include "pulse_trigger_params.svh"
// ==========================================
// Regression bench
module pulse_trigger_timing_control_tb_top;
    import pulse_trigger_pkg::*;
    typedef struct {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] ex;
    } row_t;
    localparam logic [7:0] ac = `PT_ADDR_CMD, aw = `PT_ADDR_WIDTH;
    localparam logic [7:0] ad = `PT_ADDR_DUTY, al = `PT_ADDR_DELAY;
    localparam logic [7:0] as = `PT_ADDR_STATUS, an = `PT_ADDR_MIN_SPAN;
    localparam logic [7:0] at = `PT_ADDR_MIN_START, nx = 8'h20;
    // Write, then read back; nx is unmapped
    row_t rows [28] = '{
        '{nx, 32'h0, aw, 32'h64}, '{nx, 32'h0, ad, 32'ha},
        '{nx, 32'h0, al, 32'h32}, '{nx, 32'h0, as, 32'h0},
        '{aw, 32'h95, aw, 32'h1}, '{aw, 32'h96, aw, 32'h2},
        '{aw, 32'h2faf080, aw, 32'h63ce0}, '{nx, 32'h5, nx, 32'h0},
        '{al, 32'h26fc780, al, 32'h63ce0}, '{al, 32'h0, al, 32'h0},
        '{ad, 32'h96, ad, 32'h64}, '{ad, 32'h0, ad, 32'h0},
        '{aw, 32'h2710, an, 32'h64}, '{aw, 32'h186a0, an, 32'hc8},
        '{aw, 32'hf4240, an, 32'h3e8}, '{aw, 32'hf42a4, an, 32'h2710},
        '{aw, 32'h186a0, at, 32'hfffffff4}, '{ac, 32'h6, as, 32'h12},
        '{ac, 32'h4, as, 32'h16}, '{ac, 32'h2, as, 32'h17},
        '{ac, 32'h7, as, 32'h1f}, '{ac, 32'h1, as, 32'h1f},
        '{ac, 32'h8, as, 32'h17}, '{ac, 32'h1, as, 32'h16},
        '{ac, 32'h3, as, 32'h12}, '{ac, 32'h5, as, 32'h10},
        '{ac, 32'h9, as, 32'h10}, '{as, 32'hff, as, 32'h10}};
    logic i_sys_clk = 1'b0;
    logic i_srst, i_wr, i_rd, i_trig_in, low_pol;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rdv;
    logic o_pulse, o_meas_start, o_wide_path, o_profile_domain;
    int err_total = 0, checks_done = 0, cyc = 0, meas_total = 0;
    int meas_cyc = 0, on_cnt, on_len, on_cyc, c0, n0, d0;

    always #12.5 i_sys_clk = ~i_sys_clk;
    pulse_trigger_timing_control dut_u (
        .i_sys_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_trig_in, .o_pulse, .o_meas_start, .o_wide_path, .o_profile_domain);
    pulse_partner_model prt_u (.i_sys_clk, .i_pulse(o_pulse),
        .i_low_pol(low_pol), .o_trig_n(i_trig_in), .o_on_cnt(on_cnt),
        .o_on_len(on_len), .o_on_cyc(on_cyc));
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (o_meas_start === 1'b1) begin
            meas_total <= meas_total + 1;
            meas_cyc <= cyc;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_in(input int v, input int lo, input int hi);
        checks_done++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h..%h", $time, v, lo, hi);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 rdv = o_rdata;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // About 1730 cycles expected; over nine times that (16000) before giving up
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        i_srst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h0;
        i_wdata = 32'h0;
        low_pol = 1'b0;
        idle(3);
        i_srst <= 1'b0;
        foreach (rows[k]) begin
            wr(rows[k].wa, rows[k].wd);
            rd(rows[k].ra);
            chk(rdv, rows[k].ex);
        end
        $display("test register table done");
        // Duty zero stops pulses, so the idle level shows
        idle(20);
        chk({31'h0, o_pulse}, 32'h0);
        wr(ac, 32'h6);
        low_pol <= 1'b1;
        idle(20);
        chk({31'h0, o_pulse}, 32'h1);
        wr(aw, 32'h1f4);
        wr(ad, 32'h32);
        idle(400);
        n0 = on_cnt;
        d0 = on_cyc;
        idle(400);
        chk_in(on_len, 16, 24);
        chk_in(on_cyc - d0, 1, 224);
        chk_in(on_cnt - n0, 5, 11);
        wr(ac, 32'h5);
        low_pol <= 1'b0;
        idle(200);
        chk_in(on_len, 16, 24);
        $display("test internal pulses done");
        wr(ac, 32'h4);
        idle(5);
        c0 = meas_total;
        n0 = on_cnt;
        idle(200);
        chk_in(meas_total - c0, 0, 0);
        repeat (3) begin
            prt_u.fire(3);
            idle(40);
        end
        chk_in(meas_total - c0, 3, 3);
        chk_in(on_cnt - n0, 3, 3);
        wr(al, 32'h7d0);
        c0 = cyc;
        prt_u.fire(3);
        idle(150);
        chk_in(meas_cyc - c0, 80, 95);
        wr(ac, 32'h7);
        c0 = cyc;
        prt_u.fire(2);
        idle(60);
        chk_in(meas_cyc - c0, 3, 10);
        chk({31'h0, o_wide_path}, 32'h1);
        chk({31'h0, o_profile_domain}, 32'h1);
        $display("test external trigger done");
        i_srst <= 1'b1;
        idle(3);
        i_srst <= 1'b0;
        rd(as);
        chk(rdv, 32'h0);
        rd(aw);
        chk(rdv, 32'h64);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule // pulse_trigger_timing_control_tb_top
